// ==== include/csf_pkg.sv ====
`default_nettype none
package csf_pkg;
   // core register bank addresses (bank 63 linear)
   localparam logic [12:0] ADDR_STATUS_SHADOW  = 13'h1FE4;
   localparam logic [12:0] ADDR_WREG_SHADOW    = 13'h1FE5;
   localparam logic [12:0] ADDR_BSR_SHADOW     = 13'h1FE6;
   localparam logic [12:0] ADDR_PCLATH_SHADOW  = 13'h1FE7;
   localparam logic [12:0] ADDR_PTR0L_SHADOW   = 13'h1FE8;
   localparam logic [12:0] ADDR_PTR0H_SHADOW   = 13'h1FE9;
   localparam logic [12:0] ADDR_PTR1L_SHADOW   = 13'h1FEA;
   localparam logic [12:0] ADDR_PTR1H_SHADOW   = 13'h1FEB;
   localparam logic [12:0] ADDR_HOLE           = 13'h1FEC;
   localparam logic [12:0] ADDR_STACK_PTR      = 13'h1FED;
   localparam logic [12:0] ADDR_STACK_TOP_LOW  = 13'h1FEE;
   localparam logic [12:0] ADDR_STACK_TOP_HIGH = 13'h1FEF;
   // flags register address, a local choice for this core
   localparam logic [12:0] ADDR_FLAGS          = 13'h0003;
   // field positions of the flags register
   localparam int BIT_CARRY    = 0;
   localparam int BIT_HALF     = 1;
   localparam int BIT_ZERO     = 2;
   localparam int BIT_POWERDN  = 3;
   localparam int BIT_WDEXPIRY = 4;
   // reset values and widths
   localparam logic [4:0] STACK_PTR_RESET = 5'h1F;
   localparam logic [2:0] ARITH_POR_RESET = 3'h0;
   localparam logic [7:0] SHADOW_INIT     = 8'h00;
   // alu operations
   typedef enum logic [3:0] {
      CSF_OP_NONE     = 4'h0,
      CSF_OP_ADD      = 4'h1,
      CSF_OP_SUB      = 4'h2,
      CSF_OP_AND      = 4'h3,
      CSF_OP_OR       = 4'h4,
      CSF_OP_XOR      = 4'h5,
      CSF_OP_ROR      = 4'h6,
      CSF_OP_ROL      = 4'h7,
      CSF_OP_CLR      = 4'h8,
      CSF_OP_MOVE     = 4'h9,
      CSF_OP_INC      = 4'hA,
      CSF_OP_DEC      = 4'hB,
      CSF_OP_COMP     = 4'hC,
      CSF_OP_SWAP     = 4'hD
   } csf_op_e;
   // reset cause
   typedef enum logic [1:0] {
      CSF_RST_NONE = 2'b00,
      CSF_RST_POR  = 2'b01,
      CSF_RST_PIN  = 2'b10,
      CSF_RST_WDOG = 2'b11
   } csf_rst_e;
endpackage
`default_nettype wire

// ==== include/csf_alu_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface csf_alu_if;
   import csf_pkg::*;
   csf_op_e    op;
   logic [7:0] opA;
   logic [7:0] opB;
   logic       carryIn;
   logic [7:0] result;
   logic       zeroOut;
   logic       halfOut;
   logic       carryOut;
   logic       zeroUpd;
   logic       halfUpd;
   logic       carryUpd;
   modport core (output op, opA, opB, carryIn,
                 input result, zeroOut, halfOut, carryOut, zeroUpd, halfUpd, carryUpd);
   modport alu  (input op, opA, opB, carryIn,
                 output result, zeroOut, halfOut, carryOut, zeroUpd, halfUpd, carryUpd);
endinterface
`default_nettype wire

// ==== hdl/csf_alu.sv ====
`timescale 1ns/1ps
`default_nettype none
module csf_alu (
   csf_alu_if.alu bus
);
   import csf_pkg::*;

   logic [4:0] lowSum;
   logic [8:0] fullSum;
   logic [7:0] addend;
   logic       addLike;

   // subtraction adds the two's complement of the second operand
   always_comb begin
      addLike = 1'b0;
      addend  = bus.opB;
      if (bus.op == CSF_OP_ADD) begin
         addLike = 1'b1;
      end else if (bus.op == CSF_OP_SUB) begin
         addLike = 1'b1;
         addend  = ~bus.opB;
      end
   end

   // carry-in of one completes the complement, so carry=1 means no borrow
   assign lowSum  = {1'b0, bus.opA[3:0]} + {1'b0, addend[3:0]}
                    + {4'h0, bus.op == CSF_OP_SUB};
   assign fullSum = {1'b0, bus.opA} + {1'b0, addend} + {8'h00, bus.op == CSF_OP_SUB};

   // result and flag-update masks per operation
   always_comb begin
      bus.result   = 8'h00;
      bus.halfOut  = 1'b0;
      bus.carryOut = 1'b0;
      bus.zeroUpd  = 1'b0;
      bus.halfUpd  = 1'b0;
      bus.carryUpd = 1'b0;
      case (bus.op)
         CSF_OP_ADD, CSF_OP_SUB: begin
            bus.result   = fullSum[7:0];
            bus.halfOut  = lowSum[4];
            bus.carryOut = fullSum[8];
            bus.zeroUpd  = addLike;
            bus.halfUpd  = addLike;
            bus.carryUpd = addLike;
         end
         CSF_OP_AND: begin
            bus.result  = bus.opA & bus.opB;
            bus.zeroUpd = 1'b1;
         end
         CSF_OP_OR: begin
            bus.result  = bus.opA | bus.opB;
            bus.zeroUpd = 1'b1;
         end
         CSF_OP_XOR: begin
            bus.result  = bus.opA ^ bus.opB;
            bus.zeroUpd = 1'b1;
         end
         CSF_OP_ROR: begin
            bus.result   = {bus.carryIn, bus.opA[7:1]};
            bus.carryOut = bus.opA[0];
            bus.carryUpd = 1'b1;
         end
         CSF_OP_ROL: begin
            bus.result   = {bus.opA[6:0], bus.carryIn};
            bus.carryOut = bus.opA[7];
            bus.carryUpd = 1'b1;
         end
         CSF_OP_CLR: begin
            bus.result  = 8'h00;
            bus.zeroUpd = 1'b1;
         end
         CSF_OP_INC: begin
            bus.result  = bus.opA + 8'h01;
            bus.zeroUpd = 1'b1;
         end
         CSF_OP_DEC: begin
            bus.result  = bus.opA - 8'h01;
            bus.zeroUpd = 1'b1;
         end
         CSF_OP_COMP: begin
            bus.result  = ~bus.opA;
            bus.zeroUpd = 1'b1;
         end
         CSF_OP_SWAP: begin
            bus.result = {bus.opA[3:0], bus.opA[7:4]}; // no flags touched
         end
         CSF_OP_MOVE: begin
            bus.result = bus.opB;
         end
         default: begin
            bus.result = 8'h00;
         end
      endcase
   end

   assign bus.zeroOut = (bus.result == 8'h00);
endmodule
`default_nettype wire

// ==== hdl/csf_core_flags.sv ====
// Function
// - flag-affecting op to status skips data write
// - expiry and powerdown flags ignore software writes
// - clearing status gives 000u u1uu
// - subtract carries are inverted borrows
// - subtract adds two's complement of operand
// - rotates load carry from shifted-out bit
// - expiry flag set by power-up/kick/halt, cleared timeout
// - powerdown set by power-up/kick, cleared halt
// - zero flag follows result equals zero
// - half carry from bit three carry-out
// - carry from most significant bit carry-out
// - reset values of flags depend on reset type
// - working and pointer shadows kept over pin reset
// - bank select shadow has five bits
// - pc latch shadow seven bits, top zero
// - stack pointer five bits, resets to ones
// - stack top high seven bits, top zero
// - unimplemented core locations read zero
`timescale 1ns/1ps
`default_nettype none
module csf_core_flags (
   input  wire logic            clock,
   input  wire logic            sys_rst,
   input  wire csf_pkg::csf_rst_e rstCause,
   input  wire logic            execValid,
   input  wire csf_pkg::csf_op_e execOp,
   input  wire logic [7:0]      operandA,
   input  wire logic [7:0]      operandB,
   input  wire logic            destWrite,
   input  wire logic [12:0]     destAddr,
   input  wire logic            kickOp,
   input  wire logic            haltOp,
   input  wire logic            watchdogTimeout,
   input  wire logic [12:0]     readAddr,
   output logic [7:0]           readData,
   output logic [7:0]           aluResult,
   output logic [7:0]           flagsOut
);
   import csf_pkg::*;

   csf_alu_if alu ();

   logic [2:0] arith_reg;   // zero, half, carry at bits 2..0
   logic       expiry_reg;
   logic       powerdn_reg;
   logic [7:0] statusShad_reg;
   logic [7:0] wregShad_reg;
   logic [4:0] bsrShad_reg;
   logic [6:0] pclathShad_reg;
   logic [7:0] ptrShad_reg [4];
   logic [4:0] stackPtr_reg;
   logic [7:0] stackTopLow_reg;
   logic [6:0] stackTopHigh_reg;
   logic [2:0] arith_next;
   logic       wrFlags;
   logic       isPor;
   logic [7:0] rdNext;
   logic [7:0] flagView;

   csf_alu u_alu (
      .bus (alu.alu)
   );

   assign alu.op      = execValid ? execOp : CSF_OP_NONE;
   assign alu.opA     = operandA;
   assign alu.opB     = operandB;
   assign alu.carryIn = arith_reg[BIT_CARRY];

   assign wrFlags = execValid && destWrite && (destAddr == ADDR_FLAGS);
   // power-on and brown-out share one cause code
   assign isPor   = sys_rst && (rstCause == CSF_RST_POR);

   // arithmetic flags: an op that moves any of them blocks the whole data write,
   // so clearing the flags register leaves half carry and carry as they were
   always_comb begin
      arith_next = arith_reg;
      if (wrFlags && !(alu.zeroUpd || alu.halfUpd || alu.carryUpd)) begin
         arith_next = alu.result[BIT_ZERO:BIT_CARRY];
      end
      if (execValid && alu.zeroUpd) arith_next[BIT_ZERO] = alu.zeroOut;
      if (execValid && alu.halfUpd) arith_next[BIT_HALF] = alu.halfOut;
      if (execValid && alu.carryUpd) arith_next[BIT_CARRY] = alu.carryOut;
   end

   // other resets keep the arithmetic flags; clear then leaves 000u u1uu
   always_ff @(posedge clock) begin
      if (isPor) begin
         arith_reg <= ARITH_POR_RESET;
      end else if (!sys_rst) begin
         arith_reg <= arith_next;
      end
   end

   // reset-cause flags: only hardware events, writes never reach them
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         case (rstCause)
            CSF_RST_POR: begin
               expiry_reg  <= 1'b1;
               powerdn_reg <= 1'b1;
            end
            CSF_RST_WDOG: begin
               expiry_reg <= 1'b0;
            end
            default: begin
               expiry_reg <= expiry_reg; // pin reset keeps the cause
            end
         endcase
      end else if (watchdogTimeout) begin
         expiry_reg <= 1'b0;
      end else if (kickOp) begin
         expiry_reg  <= 1'b1;
         powerdn_reg <= 1'b1;
      end else if (haltOp) begin
         expiry_reg  <= 1'b1;
         powerdn_reg <= 1'b0;
      end
   end

   // shadows: written as plain registers, never reset so pin reset keeps them
   always_ff @(posedge clock) begin
      if (!sys_rst && execValid && destWrite) begin
         case (destAddr)
            ADDR_STATUS_SHADOW: statusShad_reg <= {5'h00, alu.result[2:0]};
            ADDR_WREG_SHADOW:   wregShad_reg   <= alu.result;
            ADDR_BSR_SHADOW:    bsrShad_reg    <= alu.result[4:0];
            ADDR_PCLATH_SHADOW: pclathShad_reg <= alu.result[6:0];
            ADDR_STACK_TOP_LOW: stackTopLow_reg <= alu.result;
            ADDR_STACK_TOP_HIGH: stackTopHigh_reg <= alu.result[6:0];
            default: begin
            end
         endcase
      end
   end

   // four pointer shadows share one decode
   for (genvar i = 0; i < 4; i++) begin : g_ptr
      always_ff @(posedge clock) begin
         if (!sys_rst && execValid && destWrite
             && destAddr == ADDR_PTR0L_SHADOW + 13'(i)) begin
            ptrShad_reg[i] <= alu.result;
         end
      end
   end

   // stack pointer returns to all ones on any reset
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         stackPtr_reg <= STACK_PTR_RESET;
      end else if (execValid && destWrite && destAddr == ADDR_STACK_PTR) begin
         stackPtr_reg <= alu.result[4:0];
      end
   end

   assign flagView = {3'b000, expiry_reg, powerdn_reg, arith_reg};

   // read mux; holes and upper bits come back as zero
   always_comb begin
      case (readAddr)
         ADDR_FLAGS:          rdNext = flagView;
         ADDR_STATUS_SHADOW:  rdNext = statusShad_reg;
         ADDR_WREG_SHADOW:    rdNext = wregShad_reg;
         ADDR_BSR_SHADOW:     rdNext = {3'b000, bsrShad_reg};
         ADDR_PCLATH_SHADOW:  rdNext = {1'b0, pclathShad_reg};
         ADDR_PTR0L_SHADOW:   rdNext = ptrShad_reg[0];
         ADDR_PTR0H_SHADOW:   rdNext = ptrShad_reg[1];
         ADDR_PTR1L_SHADOW:   rdNext = ptrShad_reg[2];
         ADDR_PTR1H_SHADOW:   rdNext = ptrShad_reg[3];
         ADDR_STACK_PTR:      rdNext = {3'b000, stackPtr_reg};
         ADDR_STACK_TOP_LOW:  rdNext = stackTopLow_reg;
         ADDR_STACK_TOP_HIGH: rdNext = {1'b0, stackTopHigh_reg};
         default:             rdNext = 8'h00;
      endcase
   end

   // registered outputs, one cycle after the address or operation; flagsOut trails the flag state by a cycle
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         readData  <= 8'h00;
         aluResult <= 8'h00;
         flagsOut  <= 8'h00;
      end else begin
         readData  <= rdNext;
         aluResult <= alu.result;
         flagsOut  <= flagView;
      end
   end
endmodule
`default_nettype wire

// ==== verif/csf_core_flags_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module csf_core_flags_properties (
   input wire logic              clock,
   input wire logic              sys_rst,
   input wire csf_pkg::csf_rst_e rstCause,
   input wire logic              kickOp,
   input wire logic              haltOp,
   input wire logic              watchdogTimeout,
   input wire logic [12:0]       readAddr,
   input wire logic [7:0]        readData,
   input wire logic [7:0]        flagsOut
);
   import csf_pkg::*;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   // flag events land in state at once, flagsOut trails by a cycle
   unused_bits_a: assert property (flagsOut[7:5] == 3'h0)
      else $error("flags upper bits set");
   por_values_a: assert property (disable iff (1'b0)
      sys_rst && rstCause == CSF_RST_POR ##1 !sys_rst && !kickOp && !haltOp
      && !watchdogTimeout |=> flagsOut == 8'h18) else $error("bad flags after power-on");
   timeout_clear_a: assert property (watchdogTimeout |-> ##2 !flagsOut[4])
      else $error("expiry flag not cleared");
   kick_sets_a: assert property (kickOp && !watchdogTimeout |-> ##2 flagsOut[4:3] == 2'b11)
      else $error("kick did not set cause flags");
   halt_clears_a: assert property (
      haltOp && !kickOp && !watchdogTimeout |-> ##2 flagsOut[4:3] == 2'b10)
      else $error("halt gave wrong cause flags");
   // no event: cause flags hold, whatever software writes
   cause_hold_a: assert property (
      !sys_rst && !kickOp && !haltOp && !watchdogTimeout ##1 1'b1
      |=> flagsOut[4:3] == $past(flagsOut[4:3])) else $error("cause flags moved");
   hole_zero_a: assert property (readAddr == ADDR_HOLE |=> readData == 8'h00)
      else $error("hole not zero");
   bank_width_a: assert property (readAddr == ADDR_BSR_SHADOW |=> readData[7:5] == 3'h0)
      else $error("bank shadow too wide");
   latch_top_a: assert property (readAddr == ADDR_PCLATH_SHADOW |=> !readData[7])
      else $error("latch shadow top bit set");
   stack_top_a: assert property (readAddr == ADDR_STACK_TOP_HIGH |=> !readData[7])
      else $error("stack top high bit set");
   cover property (kickOp);
   cover property (haltOp);
   cover property (sys_rst ##1 !sys_rst);
endmodule
bind csf_core_flags csf_core_flags_properties csf_core_flags_properties_inst (
   .clock, .sys_rst, .rstCause, .kickOp, .haltOp, .watchdogTimeout,
   .readAddr, .readData, .flagsOut);
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   import csf_pkg::*;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   csf_rst_e    rstCause = CSF_RST_POR;
   logic        execValid = 1'b0;
   csf_op_e     execOp = CSF_OP_NONE;
   logic [7:0]  operandA = 8'h00;
   logic [7:0]  operandB = 8'h00;
   logic        destWrite = 1'b0;
   logic [12:0] destAddr = 13'h0000;
   logic [12:0] readAddr = 13'h0000;
   logic        kickOp = 1'b0;
   logic        haltOp = 1'b0;
   logic        watchdogTimeout = 1'b0;
   wire  [7:0]  readData;
   wire  [7:0]  aluResult;
   wire  [7:0]  flagsOut;
   logic [7:0]  mf;
   logic [7:0]  r;
   logic [8:0]  s;
   logic [4:0]  h;
   integer      errCount = 0;
   integer      comparisons = 0;
   integer      seed = 32'hccfe;
   integer      i;
   csf_op_e     ops [12] = '{CSF_OP_ADD, CSF_OP_SUB, CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR,
                             CSF_OP_ROR, CSF_OP_ROL, CSF_OP_INC, CSF_OP_DEC, CSF_OP_COMP,
                             CSF_OP_SWAP, CSF_OP_MOVE};
   logic [12:0] sa [10] = '{ADDR_WREG_SHADOW, ADDR_STATUS_SHADOW, ADDR_BSR_SHADOW,
                            ADDR_PCLATH_SHADOW, ADDR_HOLE, ADDR_STACK_PTR,
                            ADDR_STACK_TOP_HIGH, ADDR_PTR0L_SHADOW, ADDR_PTR1H_SHADOW,
                            ADDR_STACK_TOP_LOW};
   logic [7:0]  sm [10] = '{8'hA5, 8'h05, 8'h05, 8'h25, 8'h00, 8'h05, 8'h25, 8'hA5, 8'hA5,
                            8'hA5};

   // 125 MHz
   always #4 clock = ~clock;

   csf_core_flags csf_core_flags_inst (
      .clock, .sys_rst, .rstCause, .execValid, .execOp, .operandA, .operandB,
      .destWrite, .destAddr, .kickOp, .haltOp, .watchdogTimeout, .readAddr,
      .readData, .aluResult, .flagsOut);

   task chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         errCount++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask

   task giveVerdict;
      $display("mismatches %0d of %0d comparisons", errCount, comparisons);
      if (errCount == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // one instruction; the model tracks flags as the core should
   task op(input csf_op_e o, input logic [7:0] a, input logic [7:0] b,
           input logic w, input logic [12:0] d);
      @(posedge clock);
      execValid <= 1'b1;
      execOp <= o;
      operandA <= a;
      operandB <= b;
      destWrite <= w;
      destAddr <= d;
      // subtract is a plus the two's complement of b
      s = (o == CSF_OP_SUB) ? {1'b0, a} + {1'b0, ~b} + 9'h001 : {1'b0, a} + {1'b0, b};
      h = (o == CSF_OP_SUB) ? {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01
                            : {1'b0, a[3:0]} + {1'b0, b[3:0]};
      case (o)
         CSF_OP_AND:  r = a & b;
         CSF_OP_OR:   r = a | b;
         CSF_OP_XOR:  r = a ^ b;
         CSF_OP_ROR:  r = {mf[0], a[7:1]};
         CSF_OP_ROL:  r = {a[6:0], mf[0]};
         CSF_OP_INC:  r = a + 8'h01;
         CSF_OP_DEC:  r = a - 8'h01;
         CSF_OP_COMP: r = ~a;
         CSF_OP_SWAP: r = {a[3:0], a[7:4]};
         CSF_OP_MOVE: r = b;
         CSF_OP_CLR:  r = 8'h00;
         default:     r = s[7:0];
      endcase
      // only ops that touch no flag let data into the flags register
      if (w && d == ADDR_FLAGS && (o == CSF_OP_MOVE || o == CSF_OP_SWAP))
         mf[2:0] = r[2:0];
      if (o == CSF_OP_ADD || o == CSF_OP_SUB)
         mf[2:0] = {r == 8'h00, h[4], s[8]};
      else if (o == CSF_OP_ROR)
         mf[0] = a[0];
      else if (o == CSF_OP_ROL)
         mf[0] = a[7];
      else if (o != CSF_OP_MOVE && o != CSF_OP_SWAP)
         mf[2] = (r == 8'h00);
      @(posedge clock);
      execValid <= 1'b0;
      #1 chk(aluResult, r);
      @(posedge clock);
      #1 chk(flagsOut, mf);
   endtask

   // k: 0 halt, 1 kick, 2 watchdog expiry
   task ev(input int k);
      @(posedge clock);
      {watchdogTimeout, kickOp, haltOp} <= 3'b001 << k;
      if (k == 0)
         mf[4:3] = 2'b10;
      else if (k == 1)
         mf[4:3] = 2'b11;
      else
         mf[4] = 1'b0;
      @(posedge clock);
      {watchdogTimeout, kickOp, haltOp} <= 3'b000;
      @(posedge clock);
      #1 chk(flagsOut, mf);
   endtask

   task rd(input logic [12:0] a, input logic [7:0] e);
      @(posedge clock);
      readAddr <= a;
      @(posedge clock);
      #1 chk(readData, e);
   endtask

   task rst(input csf_rst_e c);
      @(posedge clock);
      sys_rst <= 1'b1;
      rstCause <= c;
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      if (c == CSF_RST_POR)
         mf = 8'h18;
      if (c == CSF_RST_WDOG)
         mf[4] = 1'b0;
   endtask

   // hang guard, far past the few hundred cycles the run needs
   initial begin
      #200000;
      errCount++;
      giveVerdict();
   end

   initial begin
      rst(CSF_RST_POR);
      rd(ADDR_STACK_PTR, 8'h1F);
      chk(flagsOut, mf);
      op(CSF_OP_SUB, 8'h42, 8'h42, 1'b0, ADDR_HOLE);
      op(CSF_OP_SUB, 8'h10, 8'h01, 1'b0, ADDR_HOLE);
      op(CSF_OP_ADD, 8'h0F, 8'h01, 1'b0, ADDR_HOLE);
      for (i = 0; i < 48; i++)
         op(ops[i % 12], 8'($random(seed)), 8'($random(seed)), 1'b1,
            i[2] ? ADDR_FLAGS : ADDR_PTR0L_SHADOW);
      // data writes into the flags register
      op(CSF_OP_MOVE, 8'hE7, 8'hE7, 1'b1, ADDR_FLAGS);
      op(CSF_OP_MOVE, 8'hE0, 8'hE0, 1'b1, ADDR_FLAGS);
      op(CSF_OP_ADD, 8'hFF, 8'h01, 1'b1, ADDR_FLAGS);
      op(CSF_OP_MOVE, 8'h02, 8'h02, 1'b1, ADDR_FLAGS);
      op(CSF_OP_CLR, 8'h5A, 8'h5A, 1'b1, ADDR_FLAGS);
      for (i = 0; i < 3; i++)
         ev(i);
      op(CSF_OP_MOVE, 8'h3C, 8'h3C, 1'b1, ADDR_FLAGS);
      ev(1);
      op(CSF_OP_ROR, 8'h01, 8'h00, 1'b0, ADDR_HOLE);
      // core bank: write A5, read the implemented bits
      for (i = 0; i < 10; i++) begin
         op(CSF_OP_MOVE, 8'hA5, 8'hA5, 1'b1, sa[i]);
         rd(sa[i], sm[i]);
      end
      // pin reset keeps shadows and flags, stack pointer reloads
      rst(CSF_RST_PIN);
      rd(ADDR_WREG_SHADOW, 8'hA5);
      rd(ADDR_PTR1H_SHADOW, 8'hA5);
      rd(ADDR_STACK_TOP_HIGH, 8'h25);
      rd(ADDR_STACK_PTR, 8'h1F);
      chk(flagsOut, mf);
      op(CSF_OP_MOVE, 8'h0A, 8'h0A, 1'b1, ADDR_STACK_PTR);
      rst(CSF_RST_WDOG);
      rd(ADDR_STACK_PTR, 8'h1F);
      chk(flagsOut, mf);
      rst(CSF_RST_POR);
      rd(ADDR_HOLE, 8'h00);
      chk(flagsOut, mf);
      giveVerdict();
   end
endmodule
`default_nettype wire
